// file: hw/hsfoc_ctrl.sv
// stage protection, fan, occupancy, heartbeat and engineering menu controller with apb registers
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - fan pin is driven in heating only while fan_in_heat_enable is 1 (default).
// - lowest speed stop: fan runs two more minutes after action, auto icon flashes.
// - lowest speed low: fan keeps running after a heating or cooling action.
// - fan mode defaults auto; continuous runs fan always; button toggles, bus write sets it.
// - each stage holds on and off for the short-cycle delay counted in minute ticks, so up to one minute less.
// - stage cycles per hour are counted; at maximum, new cycles wait for next hour.
// - pending icon shows while a stage change is held back.
// - short-cycle delay of zero disables minimum on and off timing.
// - cooling setpoint writes never go below the setpoint low limit.
// - heating setpoint writes never go above the setpoint high limit.
// - assigned temperature is used only while heartbeat toggles arrive in time.
// - missing heartbeat returns current temperature to the onboard sensor.
// - occupancy follows the energy saving contact by default.
// - network occupancy command counts only when lock setting disables the contact.
// - set button with up or down toggles occupancy; set confirms; last write wins.
// - locked set button: only network changes occupancy.
// - occupancy status reads 0 occupied, 1 unoccupied.
// - unoccupied selects unoccupied setpoints and icon; occupied selects occupied ones.
// - up and down held together five seconds enter the engineering menu.
// - menu up and down step items with wrap; mode opens the item.
// - edits store only on mode; ten idle seconds back out one level each.
// - mode on the end item leaves the menu at once.
module hsfoc_ctrl import hsfoc_pkg::*; #(
  parameter int SEC_CYCLES = SEC_CYCLES_DFLT
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // plant side
  input wire logic stage_demand,
  input wire logic [15:0] sensor_temp,
  input wire logic energy_saving_contact,
  output logic stage_out,
  output logic fan_out,
  output logic fan_oe,
  // front panel
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic btn_mode,
  input wire logic btn_set,
  input wire logic btn_fan,
  output logic pending_icon,
  output logic auto_icon,
  output logic occupancy_status,
  output logic [7:0] active_cool_setpoint,
  output logic [7:0] active_heat_setpoint,
  output logic [15:0] current_temp,
  output logic menu_active,
  output logic menu_editing,
  output logic [3:0] menu_item,
  output logic [7:0] edit_value,
  output logic menu_commit
);
  // ---------------------------------------------------------------
  // time base and button edges
  // ---------------------------------------------------------------
  logic [31:0] sec_cnt, next_sec_cnt;
  logic [5:0] min_sec, next_min_sec;
  logic [5:0] hour_min, next_hour_min;
  logic sec_tick, min_tick, hour_tick, next_sec_tick, next_min_tick, next_hour_tick;
  logic [4:0] btn_prev, press;
  logic [4:0] btn_now;
  assign btn_now = {btn_fan, btn_set, btn_mode, btn_down, btn_up};
  assign press = btn_now & ~btn_prev;

  always_comb begin
    next_sec_tick = (sec_cnt == 32'(SEC_CYCLES - 1));
    next_sec_cnt = next_sec_tick ? 32'h0 : sec_cnt + 32'h1;
    next_min_tick = 1'b0;
    next_hour_tick = 1'b0;
    next_min_sec = min_sec;
    next_hour_min = hour_min;
    if (next_sec_tick) begin
      next_min_tick = (min_sec == 6'(SEC_PER_MIN - 1));
      next_min_sec = next_min_tick ? 6'h0 : min_sec + 6'h1;
      if (next_min_tick) begin
        next_hour_tick = (hour_min == 6'(MIN_PER_HOUR - 1));
        next_hour_min = next_hour_tick ? 6'h0 : hour_min + 6'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt <= 32'h0;
      min_sec <= 6'h0;
      hour_min <= 6'h0;
      sec_tick <= 1'b0;
      min_tick <= 1'b0;
      hour_tick <= 1'b0;
      btn_prev <= 5'h1f;
    end else begin
      sec_cnt <= next_sec_cnt;
      min_sec <= next_min_sec;
      hour_min <= next_hour_min;
      sec_tick <= next_sec_tick;
      min_tick <= next_min_tick;
      hour_tick <= next_hour_tick;
      btn_prev <= btn_now;
    end
  end

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic fan_in_heat_enable, heat_mode, heartbeat_toggle;
  logic [1:0] lowest_fan_speed_sel, fan_mode_sel;
  logic [7:0] cool_short_cycle_delay, cool_max_cycles_hour, heat_short_cycle_delay, heat_max_cycles_hour;
  logic [7:0] setpoint_low_limit, setpoint_high_limit, occ_cool_setpoint, occ_heat_setpoint;
  logic [7:0] unocc_cool_setpoint, unocc_heat_setpoint, heartbeat_period, panel_lock_setting;
  logic [15:0] assigned_temperature;
  logic [31:0] regs_cfg, regs_cyc, regs_lim, regs_spo, regs_spu, regs_asg, regs_occ, regs_sts, regs_tmp;
  logic [31:0] next_regs_cfg, next_regs_cyc, next_regs_lim, next_regs_spo, next_regs_spu, next_regs_asg;
  logic [31:0] next_regs_occ, next_prdata;
  logic next_pready, next_pslverr, reg_wr, occ_edit, occ_pend, occ_manual, hb_valid, stage_on;
  logic [7:0] wr_cool, wr_heat;
  hsfoc_menu_t menu_state;

  assign reg_wr = psel & penable & pwrite & pready;
  assign {heat_mode, fan_mode_sel, lowest_fan_speed_sel, fan_in_heat_enable} = regs_cfg[5:0];
  assign {heat_max_cycles_hour, heat_short_cycle_delay, cool_max_cycles_hour, cool_short_cycle_delay} = regs_cyc;
  assign {setpoint_high_limit, setpoint_low_limit} = regs_lim[15:0];
  assign {occ_heat_setpoint, occ_cool_setpoint} = regs_spo[15:0];
  assign {unocc_heat_setpoint, unocc_cool_setpoint} = regs_spu[15:0];
  assign assigned_temperature = regs_asg[15:0];
  assign heartbeat_toggle = regs_asg[HB_TOGGLE_BIT];
  assign heartbeat_period = regs_asg[HB_PERIOD_LSB +: 8];
  assign panel_lock_setting = regs_occ[LOCK_LSB +: 8];
  assign regs_sts = {22'h0, menu_editing, menu_active, hb_valid, occ_edit, auto_icon, pending_icon,
                     fan_oe, fan_out, stage_out, occupancy_status};
  assign regs_tmp = {active_heat_setpoint, active_cool_setpoint, current_temp};

  always_comb begin
    wr_cool = (pwdata[7:0] < setpoint_low_limit) ? setpoint_low_limit : pwdata[7:0];
    wr_heat = (pwdata[15:8] > setpoint_high_limit) ? setpoint_high_limit : pwdata[15:8];
    next_regs_cfg = regs_cfg;
    next_regs_cyc = regs_cyc;
    next_regs_lim = regs_lim;
    next_regs_spo = regs_spo;
    next_regs_spu = regs_spu;
    next_regs_asg = regs_asg;
    next_regs_occ = regs_occ;
    // fan button toggle, a bus write in the same cycle is newer
    if (press[4] && menu_state == MENU_USER) begin
      next_regs_cfg[CFG_FAN_MODE_LSB +: 2] = (fan_mode_sel == FAN_MODE_AUTO) ? FAN_MODE_CONT : FAN_MODE_AUTO;
    end
    if (reg_wr) begin
      if (paddr == ADDR_CFG) begin
        next_regs_cfg = {26'h0, pwdata[5:0]};
      end else if (paddr == ADDR_CYCLE) begin
        next_regs_cyc = pwdata;
      end else if (paddr == ADDR_LIMIT) begin
        next_regs_lim = {16'h0, pwdata[15:0]};
      end else if (paddr == ADDR_SP_OCC) begin
        next_regs_spo = {16'h0, wr_heat, wr_cool};
      end else if (paddr == ADDR_SP_UNOCC) begin
        next_regs_spu = {16'h0, wr_heat, wr_cool};
      end else if (paddr == ADDR_ASSIGN) begin
        next_regs_asg = {pwdata[31:24], 7'h0, pwdata[16:0]};
      end else if (paddr == ADDR_OCC) begin
        next_regs_occ = {16'h0, pwdata[15:8], 8'h0};
      end
    end
    // read data is taken at setup so it stands through the single access cycle
    next_pready = psel & ~penable;
    next_pslverr = 1'b0;
    next_prdata = 32'h0;
    if (psel && !penable) begin
      if (paddr == ADDR_CFG) begin
        next_prdata = regs_cfg;
      end else if (paddr == ADDR_CYCLE) begin
        next_prdata = regs_cyc;
      end else if (paddr == ADDR_LIMIT) begin
        next_prdata = regs_lim;
      end else if (paddr == ADDR_SP_OCC) begin
        next_prdata = regs_spo;
      end else if (paddr == ADDR_SP_UNOCC) begin
        next_prdata = regs_spu;
      end else if (paddr == ADDR_ASSIGN) begin
        next_prdata = regs_asg;
      end else if (paddr == ADDR_OCC) begin
        next_prdata = {regs_occ[31:1], occ_manual};
      end else if (paddr == ADDR_STATUS && !pwrite) begin
        next_prdata = regs_sts;
      end else if (paddr == ADDR_TEMP && !pwrite) begin
        next_prdata = regs_tmp;
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // fan heat enable 1, lowest speed stop, fan mode auto
      regs_cfg <= {26'h0, 1'b1, FAN_MODE_AUTO, FAN_SPEED_STOP, 1'b1};
      // short-cycle delays default to three minutes
      regs_cyc <= {MAX_CYCLES_RST, SHORT_CYCLE_RST, MAX_CYCLES_RST, SHORT_CYCLE_RST};
      regs_lim <= {16'h0, SP_HIGH_LIMIT_RST, SP_LOW_LIMIT_RST};
      regs_spo <= {16'h0, OCC_HEAT_RST, OCC_COOL_RST};
      regs_spu <= {16'h0, UNOCC_HEAT_RST, UNOCC_COOL_RST};
      regs_asg <= {HB_PERIOD_RST, 24'h0};
      regs_occ <= {16'h0, LOCK_RST, 8'h0};
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      regs_cfg <= next_regs_cfg;
      regs_cyc <= next_regs_cyc;
      regs_lim <= next_regs_lim;
      regs_spo <= next_regs_spo;
      regs_spu <= next_regs_spu;
      regs_asg <= next_regs_asg;
      regs_occ <= next_regs_occ;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------
  // stage protection and fan
  // ---------------------------------------------------------------
  logic [7:0] stage_min, next_stage_min, cyc_cnt, next_cyc_cnt, sc_dly, max_cyc;
  logic [6:0] fan_dly, next_fan_dly;
  logic next_stage_on, want, timer_ok, cyc_ok, go, fan_run, next_fan_run, flash, next_flash;
  logic next_pending, next_auto_icon, next_fan_oe;

  always_comb begin
    sc_dly = heat_mode ? heat_short_cycle_delay : cool_short_cycle_delay;
    max_cyc = heat_mode ? heat_max_cycles_hour : cool_max_cycles_hour;
    want = (stage_demand != stage_on);
    // minimum on and off time, zero skips it
    timer_ok = (sc_dly == 8'h0) || (stage_min >= sc_dly);
    // hourly cycle cap only blocks turning on
    cyc_ok = stage_on || (cyc_cnt < max_cyc);
    go = want && timer_ok && cyc_ok;
    next_stage_on = go ? stage_demand : stage_on;
    next_stage_min = stage_min;
    if (go) begin
      next_stage_min = 8'h0;
    end else if (min_tick && stage_min != 8'hff) begin
      next_stage_min = stage_min + 8'h1;
    end
    next_cyc_cnt = hour_tick ? 8'h0 : cyc_cnt;
    if (go && stage_demand && next_cyc_cnt != 8'hff) begin
      next_cyc_cnt = next_cyc_cnt + 8'h1;
    end
    next_pending = want && !(timer_ok && cyc_ok);
    next_fan_run = fan_run;
    next_fan_dly = fan_dly;
    next_flash = sec_tick ? ~flash : flash;
    if (fan_mode_sel == FAN_MODE_CONT || stage_on) begin
      // continuous mode runs the fan regardless of demand
      next_fan_run = 1'b1;
      next_fan_dly = 7'h0;
      // stage going off in auto with stop arms the delay
      if (fan_mode_sel != FAN_MODE_CONT && go && lowest_fan_speed_sel == FAN_SPEED_STOP) begin
        next_fan_dly = 7'(FAN_OFF_SEC);
      end
    end else if (fan_dly != 7'h0) begin
      // fan-off delay counts down on seconds
      if (sec_tick) begin
        next_fan_dly = fan_dly - 7'h1;
        next_fan_run = (fan_dly != 7'h1);
      end
    end else if (lowest_fan_speed_sel != FAN_SPEED_LOW) begin
      // only the low setting keeps the fan after an action
      next_fan_run = 1'b0;
    end
    // auto icon flashes during the delay
    next_auto_icon = (fan_mode_sel == FAN_MODE_AUTO) && ((next_fan_dly == 7'h0) || next_flash);
    // release the fan pin in heating when disabled
    next_fan_oe = !(heat_mode && !fan_in_heat_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_on <= 1'b0;
      stage_min <= 8'hff;
      cyc_cnt <= 8'h0;
      fan_run <= 1'b0;
      fan_dly <= 7'h0;
      flash <= 1'b0;
      stage_out <= 1'b0;
      fan_out <= 1'b0;
      fan_oe <= 1'b0;
      pending_icon <= 1'b0;
      auto_icon <= 1'b0;
    end else begin
      stage_on <= next_stage_on;
      stage_min <= next_stage_min;
      cyc_cnt <= next_cyc_cnt;
      fan_run <= next_fan_run;
      fan_dly <= next_fan_dly;
      flash <= next_flash;
      stage_out <= next_stage_on;
      fan_out <= next_fan_run & next_fan_oe;
      fan_oe <= next_fan_oe;
      pending_icon <= next_pending;
      auto_icon <= next_auto_icon;
    end
  end

  // ---------------------------------------------------------------
  // occupancy and heartbeat
  // ---------------------------------------------------------------
  logic contact_off, set_locked, occ_now, next_occ_edit, next_occ_pend, next_occ_manual, next_hb_valid;
  logic [7:0] hb_left, next_hb_left;

  always_comb begin
    contact_off = panel_lock_setting[LOCK_CONTACT_OFF_BIT];
    set_locked = panel_lock_setting[LOCK_SET_BTN_BIT];
    next_occ_edit = occ_edit;
    next_occ_pend = occ_pend;
    next_occ_manual = occ_manual;
    if (!contact_off || set_locked || menu_state != MENU_USER) begin
      // panel edits are dropped while the set button is locked
      next_occ_edit = 1'b0;
    end else if (occ_edit) begin
      // up or down toggles, set or mode confirms
      if (press[0] || press[1]) begin
        next_occ_pend = ~occ_pend;
      end
      if (press[3] || press[2]) begin
        next_occ_manual = occ_pend;
        next_occ_edit = 1'b0;
      end
    end else if (press[3]) begin
      next_occ_edit = 1'b1;
      next_occ_pend = occ_manual;
    end
    if (reg_wr && paddr == ADDR_OCC) begin
      next_occ_manual = pwdata[0];
    end
    // contact unless the lock setting disables it
    occ_now = contact_off ? occ_manual : energy_saving_contact;
    // a changed heartbeat bit restarts the window
    next_hb_valid = hb_valid;
    next_hb_left = hb_left;
    if (reg_wr && paddr == ADDR_ASSIGN && pwdata[HB_TOGGLE_BIT] != heartbeat_toggle) begin
      next_hb_valid = (pwdata[HB_PERIOD_LSB +: 8] != 8'h0);
      next_hb_left = pwdata[HB_PERIOD_LSB +: 8];
    end else if (sec_tick && hb_left != 8'h0) begin
      next_hb_left = hb_left - 8'h1;
      // window expired, back to the sensor
      next_hb_valid = (hb_left != 8'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      occ_edit <= 1'b0;
      occ_pend <= 1'b0;
      occ_manual <= 1'b0;
      hb_valid <= 1'b0;
      hb_left <= 8'h0;
      occupancy_status <= 1'b0;
      active_cool_setpoint <= OCC_COOL_RST;
      active_heat_setpoint <= OCC_HEAT_RST;
      current_temp <= 16'h0;
    end else begin
      occ_edit <= next_occ_edit;
      occ_pend <= next_occ_pend;
      occ_manual <= next_occ_manual;
      hb_valid <= next_hb_valid;
      hb_left <= next_hb_left;
      occupancy_status <= occ_now;
      active_cool_setpoint <= occ_now ? unocc_cool_setpoint : occ_cool_setpoint;
      active_heat_setpoint <= occ_now ? unocc_heat_setpoint : occ_heat_setpoint;
      // assigned value only while the heartbeat is alive
      current_temp <= next_hb_valid ? next_regs_asg[15:0] : sensor_temp;
    end
  end

  // ---------------------------------------------------------------
  // engineering menu
  // ---------------------------------------------------------------
  hsfoc_menu_t next_menu_state;
  logic [3:0] hold_cnt, next_hold_cnt, idle_cnt, next_idle_cnt, next_menu_item;
  logic [7:0] next_edit_value;
  logic next_menu_commit;

  always_comb begin
    next_menu_state = menu_state;
    next_menu_item = menu_item;
    next_edit_value = edit_value;
    next_menu_commit = 1'b0;
    next_hold_cnt = 4'h0;
    next_idle_cnt = idle_cnt;
    if (|press) begin
      next_idle_cnt = 4'h0;
    end else if (sec_tick && idle_cnt != 4'hf) begin
      next_idle_cnt = idle_cnt + 4'h1;
    end
    case (menu_state)
      MENU_USER: begin
        // ticks are counted while both are held; one extra tick covers the phase
        if (btn_up && btn_down) begin
          next_hold_cnt = sec_tick ? hold_cnt + 4'h1 : hold_cnt;
          if (hold_cnt > 4'(MENU_HOLD_SEC)) begin
            next_menu_state = MENU_SELECT;
            next_menu_item = 4'h0;
            next_idle_cnt = 4'h0;
          end
        end
      end
      MENU_SELECT: begin
        // stepping with wrap in both directions
        if (press[0]) begin
          next_menu_item = (menu_item == MENU_LAST_ITEM) ? 4'h0 : menu_item + 4'h1;
        end else if (press[1]) begin
          next_menu_item = (menu_item == 4'h0) ? MENU_LAST_ITEM : menu_item - 4'h1;
        end else if (press[2]) begin
          next_menu_state = (menu_item == MENU_LAST_ITEM) ? MENU_USER : MENU_EDIT;
          next_edit_value = 8'h0;
        end else if (idle_cnt >= 4'(MENU_IDLE_SEC)) begin
          // an idle period in item selection returns to user mode
          next_menu_state = MENU_USER;
        end
      end
      MENU_EDIT: begin
        if (press[0]) begin
          next_edit_value = edit_value + 8'h1;
        end else if (press[1]) begin
          next_edit_value = edit_value - 8'h1;
        end else if (press[2]) begin
          next_menu_commit = 1'b1;
          next_menu_state = MENU_SELECT;
        end else if (idle_cnt >= 4'(MENU_IDLE_SEC)) begin
          next_menu_state = MENU_SELECT;
          next_idle_cnt = 4'h0;
        end
      end
      default: begin
        next_menu_state = MENU_USER;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      menu_state <= MENU_USER;
      menu_item <= 4'h0;
      edit_value <= 8'h0;
      menu_commit <= 1'b0;
      hold_cnt <= 4'h0;
      idle_cnt <= 4'h0;
      menu_active <= 1'b0;
      menu_editing <= 1'b0;
    end else begin
      menu_state <= next_menu_state;
      menu_item <= next_menu_item;
      edit_value <= next_edit_value;
      menu_commit <= next_menu_commit;
      hold_cnt <= next_hold_cnt;
      idle_cnt <= next_idle_cnt;
      menu_active <= (next_menu_state != MENU_USER);
      menu_editing <= (next_menu_state == MENU_EDIT);
    end
  end
endmodule : hsfoc_ctrl
`default_nettype wire

// file: hw/hsfoc_pkg.sv
// constants, register map and types for the stage, fan and occupancy controller
package hsfoc_pkg;
  // ---------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SEC_NS = 1_000_000_000;
  localparam int SEC_CYCLES_DFLT = SEC_NS / CLK_PERIOD_NS;
  localparam int SEC_PER_MIN = 60;
  localparam int MIN_PER_HOUR = 60;
  localparam int FAN_OFF_MIN = 2;
  localparam int FAN_OFF_SEC = FAN_OFF_MIN * SEC_PER_MIN;
  localparam int MENU_HOLD_SEC = 5;
  localparam int MENU_IDLE_SEC = 10;
  localparam logic [3:0] MENU_LAST_ITEM = 4'hf;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CYCLE = 8'h04;
  localparam logic [7:0] ADDR_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_SP_OCC = 8'h0c;
  localparam logic [7:0] ADDR_SP_UNOCC = 8'h10;
  localparam logic [7:0] ADDR_ASSIGN = 8'h14;
  localparam logic [7:0] ADDR_OCC = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_TEMP = 8'h20;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CFG_FAN_HEAT_BIT = 0;
  localparam int CFG_LOW_FAN_LSB = 1;
  localparam int CFG_FAN_MODE_LSB = 3;
  localparam int CFG_HEAT_MODE_BIT = 5;
  localparam int HB_TOGGLE_BIT = 16;
  localparam int HB_PERIOD_LSB = 24;
  localparam int LOCK_LSB = 8;
  localparam int LOCK_CONTACT_OFF_BIT = 6;
  localparam int LOCK_SET_BTN_BIT = 7;
  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] FAN_SPEED_STOP = 2'h1;
  localparam logic [1:0] FAN_SPEED_LOW = 2'h2;
  localparam logic [1:0] FAN_MODE_AUTO = 2'h1;
  localparam logic [1:0] FAN_MODE_CONT = 2'h2;
  localparam logic [7:0] SHORT_CYCLE_RST = 8'h03;
  localparam logic [7:0] MAX_CYCLES_RST = 8'h06;
  localparam logic [7:0] SP_LOW_LIMIT_RST = 8'h12;
  localparam logic [7:0] SP_HIGH_LIMIT_RST = 8'h19;
  localparam logic [7:0] OCC_COOL_RST = 8'h18;
  localparam logic [7:0] OCC_HEAT_RST = 8'h15;
  localparam logic [7:0] UNOCC_COOL_RST = 8'h1c;
  localparam logic [7:0] UNOCC_HEAT_RST = 8'h0f;
  localparam logic [7:0] HB_PERIOD_RST = 8'h3c;
  localparam logic [7:0] LOCK_RST = 8'h00;
  typedef enum logic [1:0] {MENU_USER, MENU_SELECT, MENU_EDIT} hsfoc_menu_t;
endpackage : hsfoc_pkg

// file: test/hsfoc_asserts.sv
// port assertions for the controller
`timescale 1ns/1ps
`default_nettype none
module hsfoc_asserts import hsfoc_pkg::*; #(parameter int SEC_CYCLES = SEC_CYCLES_DFLT) (
  input wire logic pclk, presetn, psel, penable, pready, pslverr, stage_demand, stage_out, fan_out,
  input wire logic fan_oe, pending_icon, btn_up, btn_down, menu_active, menu_editing, menu_commit
);
  int hold_cnt, next_hold;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a gap in the hold restarts the count
  always_comb next_hold = (btn_up && btn_down) ? hold_cnt + 1 : 0;
  always_ff @(posedge pclk or negedge presetn) hold_cnt <= !presetn ? 0 : next_hold;
  a_apb_answer: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_fan_release: assert property (!fan_oe |-> !fan_out) else $error("released fan");
  a_stage_fan: assert property (stage_out ##1 stage_out && fan_oe |-> fan_out) else $error("fan off");
  a_stage_cause: assert property (stage_out != $past(stage_out) |-> stage_out == $past(stage_demand))
    else $error("stage moved");
  a_pending_idle: assert property (stage_demand == stage_out |=> !pending_icon) else $error("pending");
  a_menu_hold: assert property ($rose(menu_active) |-> hold_cnt >= 5 * SEC_CYCLES - 2)
    else $error("early menu");
  a_commit_pulse: assert property (menu_commit |-> $past(menu_editing) ##1 !menu_commit)
    else $error("commit");
endmodule : hsfoc_asserts
bind hsfoc_ctrl hsfoc_asserts #(.SEC_CYCLES(SEC_CYCLES)) i_asserts (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .stage_demand, .stage_out, .fan_out, .fan_oe, .pending_icon, .btn_up, .btn_down, .menu_active,
  .menu_editing, .menu_commit);
`default_nettype wire

// file: test/hsfoc_panel.sv
// front panel user model
`timescale 1ns/1ps
`default_nettype none
module hsfoc_panel (
  input wire logic pclk,
  output logic [4:0] btn
);
  initial btn = '0;
  task automatic press(input logic [4:0] m, input int n);
    btn <= m;
    repeat (n) @(posedge pclk);
    btn <= '0;
    repeat (3) @(posedge pclk);
  endtask : press
endmodule : hsfoc_panel
`default_nettype wire

// file: test/tb.sv
// bench for the controller
`timescale 1ns/1ps
`default_nettype none
module tb import hsfoc_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stage_demand, contact, stage_out, fan_out;
  logic fan_oe, pending_icon, occ, menu_active, menu_editing, aicon;
  logic [4:0] btn;
  logic [7:0] paddr, acool, aheat, c, h;
  logic [15:0] ctemp;
  logic [31:0] pwdata, prdata, rd;
  int n_fail, compares, n;
  hsfoc_panel i_pan (.pclk, .btn);
  hsfoc_ctrl #(.SEC_CYCLES(10)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .stage_demand, .sensor_temp(16'h0123), .energy_saving_contact(contact), .stage_out,
    .fan_out, .fan_oe, .btn_up(btn[4]), .btn_down(btn[3]), .btn_mode(btn[2]), .btn_set(btn[1]), .btn_fan(btn[0]),
    .pending_icon, .auto_icon(aicon), .occupancy_status(occ), .active_cool_setpoint(acool),
    .active_heat_setpoint(aheat), .current_temp(ctemp), .menu_active, .menu_editing, .menu_item(), .edit_value(),
    .menu_commit());
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : check
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, e, input logic err);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    check(pslverr, err);
    if (!w) check(rd, e);
    {psel, penable} <= 2'b00;
    if (n == 20) begin
      check(0, 1);
      end_of_test();
    end
  endtask : apb
  // bounded wait on stage or fan
  task automatic wait_for(input logic fan, input logic v);
    n = 0;
    while ((fan ? fan_out : stage_out) !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n == 3000) check(0, 1);
    if (n == 3000) end_of_test();
  endtask : wait_for
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, stage_demand, paddr, pwdata, n_fail, compares} = '0;
    contact = 1'b1;
    void'($urandom(32'he78d));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check(occ, 1'b1);
    check(acool, UNOCC_COOL_RST);
    check(aicon, 1'b1);
    apb(0, ADDR_CFG, 0, 32'h2b, 0);
    apb(0, ADDR_CYCLE, 0, 32'h06030603, 0);
    apb(1, ADDR_STATUS, 0, 0, 1);
    apb(0, 8'h24, 0, 0, 1);
    for (int k = 0; k < 6; k++) begin
      c = (k == 0) ? 8'h11 : 8'($urandom_range(30, 8));
      h = (k == 0) ? 8'h1a : 8'($urandom_range(35, 15));
      apb(1, ADDR_SP_OCC, {16'h0, h, c}, 0, 0);
      apb(0, ADDR_SP_OCC, 0, {16'h0, h > 8'h19 ? 8'h19 : h, c < 8'h12 ? 8'h12 : c}, 0);
    end
    contact <= 1'b0;
    apb(1, ADDR_OCC, 32'h1, 0, 0);
    check(occ, 1'b0);
    check(acool, c < 8'h12 ? 8'h12 : c);
    check(aheat, h > 8'h19 ? 8'h19 : h);
    apb(1, ADDR_OCC, 32'h4001, 0, 0);
    repeat (3) @(posedge pclk);
    check(occ, 1'b1);
    i_pan.press(5'h02, 2);
    i_pan.press(5'h10, 2);
    i_pan.press(5'h02, 2);
    check(occ, 1'b0);
    apb(1, ADDR_ASSIGN, 32'h0201abcd, 0, 0);
    repeat (3) @(posedge pclk);
    check(ctemp, 16'habcd);
    repeat (40) @(posedge pclk);
    check(ctemp, 16'h0123);
    $display("done regs and occupancy");
    stage_demand <= 1'b1;
    wait_for(0, 1);
    stage_demand <= 1'b0;
    repeat (2) @(posedge pclk);
    check(pending_icon, 1'b1);
    wait_for(0, 0);
    check(n >= 1190 && n <= 1800, 1'b1);
    check(fan_out, 1'b1);
    wait_for(1, 0);
    check(n >= 1150 && n <= 1210, 1'b1);
    apb(1, ADDR_CFG, 32'h0d, 0, 0);
    stage_demand <= 1'b1;
    wait_for(0, 1);
    stage_demand <= 1'b0;
    wait_for(0, 0);
    repeat (1300) @(posedge pclk);
    check(fan_out, 1'b1);
    i_pan.press(5'h01, 2);
    apb(0, ADDR_CFG, 0, 32'h15, 0);
    check(aicon, 1'b0);
    apb(1, ADDR_CFG, 32'h34, 0, 0);
    repeat (3) @(posedge pclk);
    check(fan_oe, 1'b0);
    i_pan.press(5'h18, 30);
    check(menu_active, 1'b0);
    i_pan.press(5'h18, 70);
    check(menu_active, 1'b1);
    i_pan.press(5'h04, 2);
    check(menu_editing, 1'b1);
    i_pan.press(5'h04, 2);
    check(menu_editing, 1'b0);
    repeat (130) @(posedge pclk);
    check(menu_active, 1'b0);
    i_pan.press(5'h18, 70);
    i_pan.press(5'h08, 2);
    check(menu_active, 1'b1);
    i_pan.press(5'h04, 2);
    check(menu_active, 1'b0);
    $display("done stage, fan and menu");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
